// ### bcfs_defines.svh
// Purpose: constants of the buck channel fault sequencer
// Assumes: one 100 MHz system clock
// Notes:   analog thresholds are compared outside; their figures are kept for reference
`ifndef BCFS_DEFINES_SVH
`define BCFS_DEFINES_SVH
`define BCFS_NCH         2
`define BCFS_MCLK_HZ     100000000
`define BCFS_HF_MULT     4
`define BCFS_FSW_200K    200000
`define BCFS_FSW_300K    300000
`define BCFS_FSW_400K    400000
`define BCFS_FT_PULSES   16
`define BCFS_FT_W        5
`define BCFS_NORM_PH1    2
`define BCFS_RESTART_MV  300
`define BCFS_DISCH_OHM   12
`define BCFS_OVP_PCT     117
`define BCFS_UVP_PCT     68
`define BCFS_OT_TRIP_C   150
`define BCFS_OT_EXIT_C   120
`endif

// ### bcfs_pkg.sv
// Purpose: types of the buck channel fault sequencer
// Assumes: bcfs_defines.svh on the include path
// Notes:   states are one-hot
`include "bcfs_defines.svh"
package bcfs_pkg;
  typedef enum logic [7:0] {
    ST_OFF    = 8'h01,
    ST_DISCH  = 8'h02,
    ST_SOFT   = 8'h04,
    ST_RUN    = 8'h08,
    ST_STOP   = 8'h10,
    ST_LATCH  = 8'h20,
    ST_OVHOLD = 8'h40,
    ST_THERM  = 8'h80
  } bcfs_state_t;

  typedef enum logic [1:0] {
    FSEL_200K = 2'h0,
    FSEL_300K = 2'h1,
    FSEL_400K = 2'h2
  } bcfs_fsel_t;

  typedef struct packed {
    logic enable;
    logic over_limit;
    logic out_low;
    logic ov;
    logic uv;
    logic ss_done;
    logic pwm;
    logic bot_req;
  } bcfs_ch_in_t;

  typedef struct packed {
    logic top;
    logic top_oe;
    logic bot;
    logic bot_oe;
    logic discharge;
    logic ss_active;
    logic oc_flt;
    logic ov_flt;
    logic uv_flt;
  } bcfs_ch_out_t;

  typedef struct packed {
    bcfs_ch_in_t [`BCFS_NCH-1:0] ch;
    logic                        skip_n;
    logic                        cool;
    logic                        hot;
    logic                        vin_ok;
    logic                        vcc_ok;
  } bcfs_sync_t;

  typedef struct packed {
    bcfs_state_t           st;
    logic                  en_prev;
    logic                  limit_cyc;
    logic                  oc_l;
    logic                  ov_l;
    logic                  uv_l;
    logic [`BCFS_FT_W-1:0] timer;
  } bcfs_ch_st_t;

  typedef struct packed {
    bcfs_sync_t                   s1;
    bcfs_sync_t                   s2;
    logic                         sup_prev;
    bcfs_ch_st_t [`BCFS_NCH-1:0]  ch;
    bcfs_ch_out_t [`BCFS_NCH-1:0] out;
  } bcfs_seq_st_t;

  typedef struct packed {
    logic [7:0]          div;
    logic [1:0]          phase;
    logic                hf;
    logic [`BCFS_NCH-1:0] norm;
  } bcfs_clk_st_t;
endpackage

// ### bcfs_clkgen.sv
// Purpose: high-frequency and interleaved normal-clock enables
// Assumes: i_fsel is static while running
// Notes:   normal clock is one in four high-frequency ticks, channels half a cycle apart
`timescale 1ns/10ps
`include "bcfs_defines.svh"
module bcfs_clkgen #(
  parameter int MCLK_HZ = `BCFS_MCLK_HZ
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_nrst,
  input  wire bcfs_pkg::bcfs_fsel_t  i_fsel,
  output logic                       o_hf_tick,
  output logic [`BCFS_NCH-1:0]       o_norm_tick
);
  import bcfs_pkg::*;

  if (MCLK_HZ / (`BCFS_FSW_400K * `BCFS_HF_MULT) < 2 ||
      MCLK_HZ / (`BCFS_FSW_200K * `BCFS_HF_MULT) > 256) begin : g_chk
    $error("bcfs_clkgen: MCLK_HZ out of range");
  end

  function automatic logic [7:0] hf_div(input bcfs_fsel_t f);
    unique case (f)
      FSEL_300K: hf_div = 8'(MCLK_HZ / (`BCFS_FSW_300K * `BCFS_HF_MULT) - 1);
      FSEL_400K: hf_div = 8'(MCLK_HZ / (`BCFS_FSW_400K * `BCFS_HF_MULT) - 1);
      default:   hf_div = 8'(MCLK_HZ / (`BCFS_FSW_200K * `BCFS_HF_MULT) - 1);
    endcase
  endfunction

  bcfs_clk_st_t q;
  bcfs_clk_st_t d;

  always_comb begin
    d      = q;
    d.hf   = 1'b0;
    d.norm = '0;
    if (q.div == 8'h00) begin
      d.div     = hf_div(i_fsel);
      d.hf      = 1'b1;
      d.phase   = q.phase + 2'h1;
      d.norm[0] = (q.phase == 2'h0);
      d.norm[1] = (q.phase == 2'(`BCFS_NORM_PH1));
    end else begin
      d.div = q.div - 8'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_hf_tick   = q.hf;
  assign o_norm_tick = q.norm;
endmodule

// ### bcfs_sequencer.sv
// Purpose: two-channel buck start, stop and fault sequencer
// Assumes: comparator results arrive as asynchronous levels and pass two flip-flops
// Notes:   gate outputs float while their output enable is low
`timescale 1ns/10ps
`include "bcfs_defines.svh"
// Behaviour
// - A rising enable starts soft-start only with both supplies good and the output below 0.3 V.
// - A falling enable or a latched overcurrent or undervoltage fault enters soft-stop with discharge.
// - In discharge the internal output switch stays closed until the output is below 0.3 V or, in ST_DISCH, until enable falls.
// - A restart with the output above 0.3 V discharges first and soft-starts afterwards.
// - Current above the limit turns the top drive off for the rest of that switching cycle.
// - Overcurrent for 16 consecutive normal clocks latches the channel off with both drives floating.
// - Fault latches hold until supply is removed and re-applied or enable toggles.
// - An output above the overvoltage threshold sets the overvoltage fault.
// - An overvoltage fault turns the top drive off and holds the bottom drive on in the same cycle.
// - An output below the undervoltage threshold raises the undervoltage fault.
// - Undervoltage after an overvoltage fault forces the bottom drive high.
// - Undervoltage without overvoltage for 16 consecutive normal clocks latches the channel off.
// - Over-temperature shuts down; exit only on re-applied supply or enable while cool.
// - Soft-start switches in forced continuous mode whatever the skip selection says.
// - Normal clocks come from a four-times high-frequency clock, interleaved between channels.
module bcfs_sequencer #(
  parameter int MCLK_HZ = `BCFS_MCLK_HZ
) (
  input  wire logic                                  i_mclk,
  input  wire logic                                  i_nrst,
  input  wire bcfs_pkg::bcfs_fsel_t                  i_fsel,
  input  wire logic                                  i_vcc_ok,
  input  wire logic                                  i_vin_ok,
  input  wire logic                                  i_over_temp,
  input  wire logic                                  i_die_cool,
  input  wire logic                                  i_skip_disable_n,
  input  wire bcfs_pkg::bcfs_ch_in_t [`BCFS_NCH-1:0]  i_ch,
  output bcfs_pkg::bcfs_ch_out_t [`BCFS_NCH-1:0]      o_ch,
  output bcfs_pkg::bcfs_state_t [`BCFS_NCH-1:0]       o_state
);
  import bcfs_pkg::*;

  if (`BCFS_NCH != 2 || (1 << `BCFS_FT_W) <= `BCFS_FT_PULSES) begin : g_chk
    $error("bcfs_sequencer: unsupported channel count or timer width");
  end

  localparam logic [`BCFS_FT_W-1:0] FT_LAST = `BCFS_FT_W'(`BCFS_FT_PULSES - 1);

  logic               hf_tick;
  logic [`BCFS_NCH-1:0] norm_tick;
  bcfs_seq_st_t       q;
  bcfs_seq_st_t       d;
  bcfs_sync_t         raw;
  logic [`BCFS_NCH-1:0] ft_done;

  bcfs_clkgen #(
    .MCLK_HZ (MCLK_HZ)
  ) u_clkgen (
    .i_mclk      (i_mclk),
    .i_nrst      (i_nrst),
    .i_fsel      (i_fsel),
    .o_hf_tick   (hf_tick),
    .o_norm_tick (norm_tick)
  );

  function automatic bcfs_state_t start_state(input logic out_low);
    start_state = out_low ? ST_SOFT : ST_DISCH;
  endfunction

  function automatic logic is_active(input bcfs_state_t s);
    is_active = (s == ST_SOFT) || (s == ST_RUN);
  endfunction

  assign raw.ch     = i_ch;
  assign raw.skip_n = i_skip_disable_n;
  assign raw.cool   = i_die_cool;
  assign raw.hot    = i_over_temp;
  assign raw.vin_ok = i_vin_ok;
  assign raw.vcc_ok = i_vcc_ok;

  always_comb begin
    automatic logic        sup_ok = 1'b0;
    automatic logic        sup_rise = 1'b0;
    automatic logic        en_rise = 1'b0;
    automatic logic        en_edge = 1'b0;
    automatic logic        cond = 1'b0;
    automatic logic        act = 1'b0;
    automatic logic        top = 1'b0;
    automatic bcfs_ch_in_t ci = '0;
    automatic bcfs_ch_st_t cs = '0;
    d          = q;
    ft_done    = '0;
    d.s1       = raw;
    d.s2       = q.s1;
    sup_ok     = q.s2.vcc_ok & q.s2.vin_ok;
    sup_rise   = sup_ok & ~q.sup_prev;
    d.sup_prev = sup_ok;
    for (int c = 0; c < `BCFS_NCH; c++) begin
      ci      = q.s2.ch[c];
      cs      = q.ch[c];
      en_rise = ci.enable & ~cs.en_prev;
      en_edge = ci.enable ^ cs.en_prev;
      act     = is_active(cs.st);
      cond    = ci.over_limit | (ci.uv & ~cs.ov_l);
      d.ch[c].en_prev  = ci.enable;
      // limit flag lasts until the next normal clock of this channel
      d.ch[c].limit_cyc = norm_tick[c] ? ci.over_limit : (cs.limit_cyc | ci.over_limit);
      if (!cond || !act) begin
        d.ch[c].timer = '0;
      end else if (norm_tick[c] && cs.timer != FT_LAST) begin
        d.ch[c].timer = cs.timer + `BCFS_FT_W'(1);
      end
      ft_done[c] = act & cond & norm_tick[c] & (cs.timer == FT_LAST);
      // clear first so a fault in the same cycle still sets
      if (en_edge || !sup_ok) begin
        d.ch[c].oc_l  = 1'b0;
        d.ch[c].ov_l  = 1'b0;
        d.ch[c].uv_l  = 1'b0;
      end
      if (ft_done[c] && ci.over_limit) begin
        d.ch[c].oc_l  = 1'b1;
      end
      if (ft_done[c] && !ci.over_limit) begin
        d.ch[c].uv_l = 1'b1;
      end
      if (act && ci.ov) begin
        d.ch[c].ov_l = 1'b1;
      end
      if (q.s2.hot) begin
        d.ch[c].st = ST_THERM;
      end else if (!sup_ok && cs.st != ST_THERM) begin
        d.ch[c].st = ST_OFF;
      end else begin
        unique case (cs.st)
          ST_OFF: begin
            if ((en_rise || sup_rise) && ci.enable) d.ch[c].st = start_state(ci.out_low);
          end
          ST_DISCH: begin
            if (!ci.enable) d.ch[c].st = ST_OFF;
            else if (ci.out_low) d.ch[c].st = ST_SOFT;
          end
          ST_SOFT, ST_RUN: begin
            if (!ci.enable) d.ch[c].st = ST_STOP;
            else if (ci.ov) d.ch[c].st = ST_OVHOLD;
            else if (ft_done[c]) d.ch[c].st = ST_STOP;
            else if (cs.st == ST_SOFT && ci.ss_done) d.ch[c].st = ST_RUN;
          end
          ST_STOP: begin
            if (en_rise && !cs.oc_l && !cs.uv_l) d.ch[c].st = ST_DISCH;
            else if (ci.out_low) d.ch[c].st = (cs.oc_l || cs.uv_l) ? ST_LATCH : ST_OFF;
          end
          ST_LATCH, ST_OVHOLD: begin
            if (en_edge) d.ch[c].st = ST_OFF;
          end
          ST_THERM: begin
            if ((en_rise || sup_rise) && q.s2.cool && sup_ok) begin
              d.ch[c].st = ci.enable ? start_state(ci.out_low) : ST_OFF;
            end
          end
        endcase
      end
      top = ci.pwm & ~ci.over_limit & ~d.ch[c].limit_cyc;
      d.out[c]           = '0;
      d.out[c].oc_flt    = d.ch[c].oc_l;
      d.out[c].ov_flt    = d.ch[c].ov_l;
      d.out[c].uv_flt    = d.ch[c].uv_l | (ci.uv & is_active(d.ch[c].st));
      d.out[c].discharge = (d.ch[c].st == ST_DISCH) || (d.ch[c].st == ST_STOP);
      d.out[c].ss_active = (d.ch[c].st == ST_SOFT);
      unique case (d.ch[c].st)
        ST_SOFT: begin
          d.out[c].top_oe = 1'b1;
          d.out[c].bot_oe = 1'b1;
          d.out[c].top    = top;
          d.out[c].bot    = ~top;
        end
        ST_RUN: begin
          d.out[c].top_oe = 1'b1;
          d.out[c].bot_oe = 1'b1;
          d.out[c].top    = top;
          d.out[c].bot    = ~top & (~q.s2.skip_n | ci.bot_req);
        end
        ST_OVHOLD: begin
          d.out[c].bot_oe = 1'b1;
          d.out[c].bot    = 1'b1;
        end
        default: begin
          d.out[c].top_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '{default: '0, ch: '{default: '{st: ST_OFF, default: '0}}};
    end else begin
      q <= d;
    end
  end

  assign o_ch    = q.out;
  assign o_state = '{q.ch[1].st, q.ch[0].st};

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  property p_interleave;
    !(norm_tick[0] && norm_tick[1]);
  endproperty
  a_interleave: assert property (p_interleave) else $error("normal clocks coincide");

  for (genvar c = 0; c < `BCFS_NCH; c++) begin : g_chk_ch
    sequence s_ov_hit;
      is_active(q.ch[c].st) && q.s2.ch[c].ov && q.s2.ch[c].enable && !q.s2.hot &&
        q.s2.vcc_ok && q.s2.vin_ok;
    endsequence
    sequence s_ov_hold;
      (q.ch[c].st == ST_OVHOLD) && q.ch[c].ov_l;
    endsequence
    property p_start;
      (q.ch[c].st == ST_OFF) && q.s2.ch[c].enable && !q.ch[c].en_prev && q.s2.ch[c].out_low
        && q.s2.vcc_ok && q.s2.vin_ok && !q.s2.hot |=> (q.ch[c].st == ST_SOFT);
    endproperty
    a_start: assert property (p_start) else $error("no soft-start on enable");
    property p_fault_stop;
      ft_done[c] && q.s2.ch[c].enable && !q.s2.ch[c].ov && !q.s2.hot && q.s2.vcc_ok
        && q.s2.vin_ok |=> (q.ch[c].st == ST_STOP) && o_ch[c].discharge && !o_ch[c].top_oe;
    endproperty
    a_fault_stop: assert property (p_fault_stop) else $error("fault did not stop");
    property p_disch;
      (q.ch[c].st == ST_DISCH) && !q.s2.ch[c].out_low && q.s2.ch[c].enable && !q.s2.hot
        && q.s2.vcc_ok && q.s2.vin_ok |=> o_ch[c].discharge && (q.ch[c].st == ST_DISCH);
    endproperty
    a_disch: assert property (p_disch) else $error("discharge ended early");
    property p_limit;
      q.s2.ch[c].over_limit |=> !o_ch[c].top;
    endproperty
    a_limit: assert property (p_limit) else $error("top drive on above limit");
    property p_timer_latch;
      ft_done[c] |-> $past(q.ch[c].timer) == FT_LAST ##2 !o_ch[c].top_oe;
    endproperty
    a_timer_latch: assert property (p_timer_latch) else $error("timer expiry wrong");
    property p_hold;
      s_ov_hold and (q.s2.ch[c].enable == q.ch[c].en_prev) && !q.s2.hot && q.s2.vcc_ok
        && q.s2.vin_ok |=> s_ov_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("overvoltage latch lost");
    property p_ov_trip;
      s_ov_hit |=> s_ov_hold and (o_ch[c].bot && o_ch[c].bot_oe && !o_ch[c].top);
    endproperty
    a_ov_trip: assert property (p_ov_trip) else $error("overvoltage response wrong");
    property p_therm;
      q.s2.hot |=> (q.ch[c].st == ST_THERM) && !o_ch[c].top_oe && !o_ch[c].bot_oe;
    endproperty
    a_therm: assert property (p_therm) else $error("no thermal shutdown");
    property p_ss_ccm;
      (q.ch[c].st == ST_SOFT) && o_ch[c].ss_active |-> o_ch[c].bot == !o_ch[c].top;
    endproperty
    a_ss_ccm: assert property (p_ss_ccm) else $error("soft-start not forced continuous");
    property p_timer_clear;
      !(q.s2.ch[c].over_limit || q.s2.ch[c].uv) |=> (q.ch[c].timer == '0);
    endproperty
    a_timer_clear: assert property (p_timer_clear) else $error("fault timer kept count");
  end
endmodule

// ### bcfs_plant.sv
// Purpose: power stage and output filter of one channel
// Assumes: output settles at 1000 mV while the top drive is on
// Notes:   i_step sets how fast the output moves, prompt or slow
`timescale 1ns/10ps
module bcfs_plant (
  input  wire logic                   i_mclk,
  input  wire logic                   i_nrst,
  input  wire bcfs_pkg::bcfs_ch_out_t i_drv,
  input  wire logic [7:0]             i_step,
  output logic                        o_out_low
);
  import bcfs_pkg::*;
  logic [11:0] vo_q;
  logic [11:0] vo_d;
  always_comb begin
    vo_d = vo_q;
    if (i_drv.discharge) begin
      vo_d = (vo_q > 12'(i_step)) ? vo_q - 12'(i_step) : 12'h000;
    end else if (i_drv.top && i_drv.top_oe) begin
      vo_d = (vo_q + 12'(i_step) > 12'h3E8) ? 12'h3E8 : vo_q + 12'(i_step);
    end
  end
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      vo_q <= 12'h000;
    end else begin
      vo_q <= vo_d;
    end
  end
  // restart comparator at 300 mV
  assign o_out_low = (vo_q < 12'h12C);
endmodule

// ### test_bcfs_sequencer.sv
// Purpose: self-checking bench of the buck channel fault sequencer
// Assumes: 200 kHz switching, one normal tick every 500 clocks; 400 kHz in the last test
// Notes:   comparator levels are driven here, restart level comes from the plant
`timescale 1ns/10ps
`include "bcfs_defines.svh"
module test_bcfs_sequencer;
  import bcfs_pkg::*;
  localparam int HF   = `BCFS_MCLK_HZ / (`BCFS_FSW_200K * `BCFS_HF_MULT);
  localparam int TICK = HF * `BCFS_HF_MULT;
  localparam int TICK4 = `BCFS_MCLK_HZ / (`BCFS_FSW_400K * `BCFS_HF_MULT) * `BCFS_HF_MULT;
  logic                         i_mclk;
  logic                         i_nrst;
  logic                         vcc_ok;
  logic                         vin_ok;
  logic                         over_temp;
  logic                         die_cool;
  logic                         skip_n;
  logic [7:0]                   step;
  logic [`BCFS_NCH-1:0]         low;
  bcfs_fsel_t                   fsel;
  bcfs_ch_in_t [`BCFS_NCH-1:0]  drv;
  bcfs_ch_in_t [`BCFS_NCH-1:0]  ch_in;
  bcfs_ch_out_t [`BCFS_NCH-1:0] o_ch;
  bcfs_state_t [`BCFS_NCH-1:0]  o_state;
  int                           mismatches;
  int                           total_checks;

  bcfs_sequencer bcfs_sequencer_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_fsel(fsel),
    .i_vcc_ok(vcc_ok), .i_vin_ok(vin_ok), .i_over_temp(over_temp), .i_die_cool(die_cool),
    .i_skip_disable_n(skip_n), .i_ch(ch_in), .o_ch(o_ch), .o_state(o_state));
  for (genvar c = 0; c < `BCFS_NCH; c++) begin : g_pl
    bcfs_plant bcfs_plant_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_drv(o_ch[c]),
      .i_step(step), .o_out_low(low[c]));
  end
  always_comb begin
    ch_in = drv;
    for (int c = 0; c < `BCFS_NCH; c++) begin
      ch_in[c].out_low = low[c];
    end
  end

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_st(input string nm, input bcfs_state_t e, input bcfs_state_t g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wait_st(input int c, input bcfs_state_t s, input int n);
    int k;
    k = 0;
    while (o_state[c] !== s && k < n) begin
      cyc(1);
      k++;
    end
    chk_st("state", s, o_state[c]);
  endtask
  task automatic tog(input int c);
    drv[c].enable = 1'b0;
    cyc(6);
    drv[c].enable = 1'b1;
  endtask
  task automatic end_test(input string nm);
    $display("test %s done, mismatches %0d", nm, mismatches);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    cyc(70 * TICK);
    mismatches++;
    give_verdict;
  end

  initial begin
    i_nrst = 1'b0;
    drv = '0;
    vcc_ok = 1'b1;
    vin_ok = 1'b1;
    over_temp = 1'b0;
    die_cool = 1'b1;
    skip_n = 1'b1;
    step = 8'h28;
    fsel = FSEL_200K;
    repeat (6) @(posedge i_mclk);
    #1 i_nrst = 1'b1;
    cyc(4);
    vin_ok = 1'b0;
    drv[0].enable = 1'b1;
    cyc(10);
    chk_st("refused", ST_OFF, o_state[0]);
    drv[0].enable = 1'b0;
    vin_ok = 1'b1;
    cyc(6);
    end_test("refuse");
    drv[0].enable = 1'b1;
    drv[1].enable = 1'b1;
    wait_st(0, ST_SOFT, 10);
    cyc(2);
    chk_bit("ss_active", 1'b1, o_ch[0].ss_active);
    chk_bit("bot_fccm", 1'b1, o_ch[0].bot);
    chk_bit("bot_oe", 1'b1, o_ch[0].bot_oe);
    drv[0].pwm = 1'b1;
    drv[1].pwm = 1'b1;
    cyc(40);
    drv[0].ss_done = 1'b1;
    drv[1].ss_done = 1'b1;
    wait_st(0, ST_RUN, 10);
    wait_st(1, ST_RUN, 10);
    drv[1].pwm = 1'b0;
    cyc(4);
    chk_bit("bot_skip", 1'b0, o_ch[1].bot);
    skip_n = 1'b0;
    cyc(4);
    chk_bit("bot_skip_disable_n", 1'b1, o_ch[1].bot);
    skip_n = 1'b1;
    drv[1].pwm = 1'b1;
    end_test("start");
    drv[0].over_limit = 1'b1;
    cyc(4);
    chk_bit("top_limit", 1'b0, o_ch[0].top);
    cyc(10 * TICK);
    drv[0].over_limit = 1'b0;
    cyc(TICK + 10);
    chk_bit("top_back", 1'b1, o_ch[0].top);
    drv[0].over_limit = 1'b1;
    cyc(15 * TICK - 10);
    chk_st("no_early", ST_RUN, o_state[0]);
    wait_st(0, ST_STOP, TICK + 20);
    chk_bit("oc_flt", 1'b1, o_ch[0].oc_flt);
    chk_bit("top_oe", 1'b0, o_ch[0].top_oe);
    chk_bit("bot_oe", 1'b0, o_ch[0].bot_oe);
    chk_bit("disch", 1'b1, o_ch[0].discharge);
    chk_st("other_ch", ST_RUN, o_state[1]);
    drv[0].over_limit = 1'b0;
    wait_st(0, ST_LATCH, 100);
    cyc(TICK);
    chk_bit("oc_held", 1'b1, o_ch[0].oc_flt);
    drv[0].enable = 1'b0;
    wait_st(0, ST_OFF, 10);
    chk_bit("oc_clr", 1'b0, o_ch[0].oc_flt);
    drv[0].enable = 1'b1;
    wait_st(0, ST_RUN, 20);
    end_test("overcurrent");
    cyc(40);
    step = 8'h01;
    drv[0].enable = 1'b0;
    wait_st(0, ST_STOP, 10);
    chk_bit("disch", 1'b1, o_ch[0].discharge);
    cyc(20);
    drv[0].enable = 1'b1;
    wait_st(0, ST_DISCH, 10);
    chk_bit("still_high", 1'b0, low[0]);
    chk_bit("disch", 1'b1, o_ch[0].discharge);
    wait_st(0, ST_SOFT, 1200);
    step = 8'h28;
    wait_st(0, ST_RUN, 10);
    end_test("restart");
    cyc(40);
    drv[0].ov = 1'b1;
    wait_st(0, ST_OVHOLD, 10);
    chk_bit("ov_flt", 1'b1, o_ch[0].ov_flt);
    chk_bit("top_oe", 1'b0, o_ch[0].top_oe);
    chk_bit("bot_on", 1'b1, o_ch[0].bot);
    chk_bit("bot_oe", 1'b1, o_ch[0].bot_oe);
    drv[0].ov = 1'b0;
    drv[0].uv = 1'b1;
    cyc(2 * TICK);
    chk_st("ov_hold", ST_OVHOLD, o_state[0]);
    chk_bit("bot_uv", 1'b1, o_ch[0].bot);
    chk_bit("ov_held", 1'b1, o_ch[0].ov_flt);
    drv[0].uv = 1'b0;
    drv[0].enable = 1'b0;
    wait_st(0, ST_OFF, 10);
    chk_bit("ov_clr", 1'b0, o_ch[0].ov_flt);
    drv[0].enable = 1'b1;
    wait_st(0, ST_RUN, 200);
    end_test("overvoltage");
    drv[0].uv = 1'b1;
    cyc(5);
    chk_bit("uv_flt", 1'b1, o_ch[0].uv_flt);
    wait_st(0, ST_STOP, 16 * TICK + 20);
    chk_bit("top_oe", 1'b0, o_ch[0].top_oe);
    chk_bit("bot_oe", 1'b0, o_ch[0].bot_oe);
    drv[0].uv = 1'b0;
    wait_st(0, ST_LATCH, 100);
    tog(0);
    wait_st(0, ST_RUN, 200);
    end_test("undervoltage");
    over_temp = 1'b1;
    wait_st(0, ST_THERM, 10);
    wait_st(1, ST_THERM, 10);
    chk_bit("top_oe", 1'b0, o_ch[0].top_oe);
    over_temp = 1'b0;
    die_cool = 1'b0;
    tog(0);
    cyc(10);
    chk_st("hot_stay", ST_THERM, o_state[0]);
    die_cool = 1'b1;
    tog(0);
    cyc(10);
    chk_bit("therm_exit", 1'b1, o_state[0] !== ST_THERM);
    chk_st("other_stay", ST_THERM, o_state[1]);
    end_test("thermal");
    fsel = FSEL_400K;
    wait_st(0, ST_RUN, 200);
    drv[0].over_limit = 1'b1;
    wait_st(0, ST_STOP, 16 * TICK4 + 300);
    chk_bit("oc_fast", 1'b1, o_ch[0].oc_flt);
    end_test("fast_clock");
    give_verdict;
  end
endmodule
